// ---- hts_pkg.sv ----
package hts_pkg;

	// Seven-bit slave addresses of the two module variants
	localparam logic [6:0] ADDR_VARIANT_1 = 7'h44;
	localparam logic [6:0] ADDR_VARIANT_2 = 7'h50;

	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned NS_PER_US = 1000;

	// Times in microseconds
	localparam int unsigned T_WAKE_US = 100;
	localparam int unsigned T_CONV8_US = 550;
	localparam int unsigned T_CONV10_US = 1310;
	localparam int unsigned T_CONV12_US = 4500;
	localparam int unsigned T_CONV14_US = 16900;
	localparam int unsigned T_PROG_WIN_US = 10000;
	localparam int unsigned T_PROG_LOAD_US = 120;
	localparam int unsigned T_NVM_WR_US = 14000;

	function automatic logic [31:0] cyc_up(input int unsigned us);
		logic [31:0] c;
		c = 32'((us * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
		if (c == 32'h0) begin
			c = 32'h1;
		end
		return c;
	endfunction

	function automatic logic [31:0] cyc_dn(input int unsigned us);
		logic [31:0] c;
		c = 32'((us * NS_PER_US) / CLK_PERIOD_NS);
		if (c == 32'h0) begin
			c = 32'h1;
		end
		return c;
	endfunction

	localparam logic [31:0] WAKE_CYC = cyc_up(T_WAKE_US);
	localparam logic [31:0] CONV8_CYC = cyc_up(T_CONV8_US);
	localparam logic [31:0] CONV10_CYC = cyc_up(T_CONV10_US);
	localparam logic [31:0] CONV12_CYC = cyc_up(T_CONV12_US);
	localparam logic [31:0] CONV14_CYC = cyc_up(T_CONV14_US);
	localparam logic [31:0] PROG_WIN_CYC = cyc_dn(T_PROG_WIN_US);
	localparam logic [31:0] PROG_LOAD_CYC = cyc_up(T_PROG_LOAD_US);
	localparam logic [31:0] NVM_WR_CYC = cyc_up(T_NVM_WR_US);
	localparam logic [31:0] CNT_ONE = 32'h1;
	localparam logic [31:0] CNT_ZERO = 32'h0;

	// Three-byte commands
	localparam logic [7:0] CMD_PROG_ENTER = 8'hA0;
	localparam logic [7:0] CMD_PROG_EXIT = 8'h80;
	localparam logic [7:0] CMD_ARG_ZERO = 8'h00;

	// Non-volatile register addresses
	localparam logic [7:0] NVM_HUM_RES_RD = 8'h06;
	localparam logic [7:0] NVM_TEMP_RES_RD = 8'h11;
	localparam logic [7:0] NVM_ID_UPPER = 8'h1E;
	localparam logic [7:0] NVM_ID_LOWER = 8'h1F;
	localparam logic [7:0] NVM_HUM_RES_WR = 8'h46;
	localparam logic [7:0] NVM_TEMP_RES_WR = 8'h51;

	localparam int RES_MSB = 11;
	localparam int RES_LSB = 10;
	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [1:0] RES_14 = 2'h3;
	localparam logic [15:0] NVM_RES_RESET = 16'h0C00;
	localparam logic [15:0] NVM_NONE = 16'h0000;

	// Identity defaults: values are arbitrary
	localparam logic [15:0] ID_UPPER_DEFAULT = 16'h5A5A;
	localparam logic [15:0] ID_LOWER_DEFAULT = 16'hA5A5;

	localparam logic [1:0] STATUS_VALID = 2'h0;
	localparam logic [1:0] STATUS_STALE = 2'h1;
	localparam logic [7:0] PROG_STAT_READY = 8'h81;
	localparam logic [7:0] PROG_STAT_BUSY = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [1:0] LSB_PAD = 2'h0;

	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [1:0] WR_NONE = 2'h0;
	localparam logic [1:0] WR_ONE = 2'h1;
	localparam logic [1:0] WR_TWO = 2'h2;
	localparam logic [1:0] WR_FULL = 2'h3;
	localparam logic [2:0] BYTE_0 = 3'h0;
	localparam logic [2:0] BYTE_1 = 3'h1;
	localparam logic [2:0] BYTE_2 = 3'h2;
	localparam logic [2:0] BYTE_3 = 3'h3;
	localparam logic [2:0] BYTE_MAX = 3'h7;
	localparam logic [2:0] BYTE_STEP = 3'h1;

	typedef enum logic [2:0] {
		LK_IDLE = 3'b000,
		LK_ADDR = 3'b001,
		LK_WRITE = 3'b010,
		LK_ACK = 3'b011,
		LK_READ = 3'b100,
		LK_RACK = 3'b101
	} hts_link_t;

	typedef enum logic [1:0] {
		MS_SLEEP = 2'b00,
		MS_WAKE = 2'b01,
		MS_HUM = 2'b10,
		MS_TEMP = 2'b11
	} hts_meas_t;

	typedef struct packed {
		logic [1:0] status;
		logic [13:0] hum;
		logic [13:0] temp;
	} hts_result_t;

endpackage

// ---- hts_readout.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Serial slave at 100 and 400 kHz.
// - Answer only own fixed seven-bit address.
// - Detect START and STOP while clock high.
// - Sample data on rising clock edge.
// - Address then direction: one read, zero write.
// - Eight bits plus acknowledge bit per byte.
// - Sleep until a measurement request arrives.
// - Address with write bit and no data bytes wakes device, outside programming.
// - Humidity, then temperature, then update output.
// - Results fourteen bits, most significant first.
// - Address with read bit fetches, acknowledged.
// - Status bits then humidity; send until NACK.
// - Temperature in bytes three, four; pad low.
// - Conversion time follows configured resolutions plus wake.
// - Status valid until fetched, then stale.
// - Stale status before first measurement completes.
// - Enter programming only inside power-up window.
// - Registers accessible after enter command processing time.
// - Exit command returns to measurement mode.
// - Sixteen-bit registers; identity upper and lower.
// - Resolution read and write addresses, bits 11:10.
// - Field codes 8/10/12/14 bits, default 14.
// - Full register write-back; fourteen millisecond commit.
// - Identity is both halves concatenated.
module hts_readout #(
	parameter logic [6:0] SLAVE_ADDR = hts_pkg::ADDR_VARIANT_1,
	parameter logic [15:0] ID_UPPER = hts_pkg::ID_UPPER_DEFAULT,
	parameter logic [15:0] ID_LOWER = hts_pkg::ID_LOWER_DEFAULT,
	parameter logic [31:0] WAKE_CYC = hts_pkg::WAKE_CYC,
	parameter logic [31:0] CONV8_CYC = hts_pkg::CONV8_CYC,
	parameter logic [31:0] CONV10_CYC = hts_pkg::CONV10_CYC,
	parameter logic [31:0] CONV12_CYC = hts_pkg::CONV12_CYC,
	parameter logic [31:0] CONV14_CYC = hts_pkg::CONV14_CYC,
	parameter logic [31:0] PROG_WIN_CYC = hts_pkg::PROG_WIN_CYC,
	parameter logic [31:0] PROG_LOAD_CYC = hts_pkg::PROG_LOAD_CYC,
	parameter logic [31:0] NVM_WR_CYC = hts_pkg::NVM_WR_CYC
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N_O,
	input wire logic [13:0] HUM_DATA_I,
	input wire logic [13:0] TEMP_DATA_I,
	output hts_pkg::hts_meas_t MEAS_PHASE_O,
	output hts_pkg::hts_result_t RESULT_O,
	output logic PROG_MODE_O,
	output logic NVM_BUSY_O,
	output logic [15:0] HUM_RES_REG_O,
	output logic [15:0] TEMP_RES_REG_O
);
	import hts_pkg::*;

	function automatic logic [31:0] res_cycles(input logic [15:0] reg_val);
		logic [31:0] c;
		c = CONV14_CYC;
		unique case (reg_val[RES_MSB:RES_LSB])
			RES_8: c = CONV8_CYC;
			RES_10: c = CONV10_CYC;
			RES_12: c = CONV12_CYC;
			RES_14: c = CONV14_CYC;
		endcase
		return c;
	endfunction

	// Line synchronisers and glitch filters
	logic scl_s1_q, scl_s2_q, scl_s3_q, scl_f_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q, sda_f_q;
	wire logic scl_f_d = (scl_s2_q == scl_s3_q) ? scl_s3_q : scl_f_q;
	wire logic sda_f_d = (sda_s2_q == sda_s3_q) ? sda_s3_q : sda_f_q;
	wire logic scl_rise = scl_f_d & ~scl_f_q;
	wire logic scl_fall = ~scl_f_d & scl_f_q;
	wire logic bus_start = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
	wire logic bus_stop = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;
	wire logic bus_end = bus_start | bus_stop;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			scl_f_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else begin
			scl_s1_q <= SCL_I;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			scl_f_q <= scl_f_d;
			sda_s1_q <= SDA_I;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			sda_f_q <= sda_f_d;
		end
	end

	// Link state
	hts_link_t link_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic rw_q;
	logic nack_q;
	logic in_xfer_q;
	logic sda_oe_n_q;
	logic [2:0] rd_idx_q;
	logic [1:0] wr_cnt_q;
	logic [7:0] cmd_q, arg1_q, arg2_q;

	// Device state
	hts_meas_t meas_q;
	logic [31:0] mcnt_q;
	hts_result_t result_q;
	logic [31:0] win_q;
	logic loading_q;
	logic [31:0] lcnt_q;
	logic prog_q;
	logic nvm_busy_q;
	logic [31:0] ncnt_q;
	logic [15:0] hum_res_q, temp_res_q;
	logic [7:0] rd_ptr_q;

	wire logic addr_match = (sh_q[7:1] == SLAVE_ADDR);
	wire logic byte_done = scl_fall && (bit_q == BIT_LAST);
	wire logic [2:0] rd_idx_next = (rd_idx_q == BYTE_MAX) ? rd_idx_q : 3'(rd_idx_q + BYTE_STEP);

	// Transaction decode at STOP or repeated START
	wire logic wr_done = bus_end & in_xfer_q & ~rw_q;
	wire logic args_zero = (arg1_q == CMD_ARG_ZERO) && (arg2_q == CMD_ARG_ZERO);
	wire logic three_bytes = (wr_cnt_q == WR_FULL);
	wire logic win_open = (win_q != CNT_ZERO);
	wire logic meas_req = wr_done && (wr_cnt_q == WR_NONE) && !prog_q && !loading_q;
	wire logic enter_req = wr_done && three_bytes && args_zero && (cmd_q == CMD_PROG_ENTER)
		&& win_open && !prog_q && !loading_q;
	wire logic exit_req = wr_done && three_bytes && args_zero && (cmd_q == CMD_PROG_EXIT) && prog_q;
	wire logic cmd_is_wr = (cmd_q == NVM_HUM_RES_WR)
		|| (cmd_q == NVM_TEMP_RES_WR);
	// Any other address selects; one with no register behind it reads as zero
	wire logic sel_req = wr_done && three_bytes && args_zero && prog_q && !cmd_is_wr;
	wire logic nvm_wr_ok = wr_done && three_bytes && prog_q && !nvm_busy_q;
	wire logic hum_wr = nvm_wr_ok && (cmd_q == NVM_HUM_RES_WR);
	wire logic temp_wr = nvm_wr_ok && (cmd_q == NVM_TEMP_RES_WR);
	wire logic fetch_done = bus_end & in_xfer_q & rw_q & ~prog_q;
	wire logic meas_done = (meas_q == MS_TEMP) && (mcnt_q == CNT_ZERO);

	// Byte served for the current read position
	wire logic [15:0] nvm_word = (rd_ptr_q == NVM_HUM_RES_RD) ? hum_res_q :
		(rd_ptr_q == NVM_TEMP_RES_RD) ? temp_res_q :
		(rd_ptr_q == NVM_ID_UPPER) ? ID_UPPER :
		(rd_ptr_q == NVM_ID_LOWER) ? ID_LOWER : NVM_NONE;
	wire logic [7:0] prog_stat = nvm_busy_q ? PROG_STAT_BUSY : PROG_STAT_READY;
	wire logic [7:0] norm_byte = (rd_idx_q == BYTE_0) ? {result_q.status, result_q.hum[13:8]} :
		(rd_idx_q == BYTE_1) ? result_q.hum[7:0] :
		(rd_idx_q == BYTE_2) ? result_q.temp[13:6] :
		(rd_idx_q == BYTE_3) ? {result_q.temp[5:0], LSB_PAD} : IDLE_BYTE;
	wire logic [7:0] prog_byte = (rd_idx_q == BYTE_0) ? prog_stat :
		(rd_idx_q == BYTE_1) ? nvm_word[15:8] :
		(rd_idx_q == BYTE_2) ? nvm_word[7:0] : IDLE_BYTE;
	wire logic [7:0] tx_pick = prog_q ? prog_byte : norm_byte;

	// Serial slave: START/STOP override any state
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			link_q <= LK_IDLE;
			bit_q <= BIT_ZERO;
			sh_q <= CMD_ARG_ZERO;
			tx_q <= IDLE_BYTE;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
			rd_idx_q <= BYTE_0;
		end else if (bus_start) begin
			link_q <= LK_ADDR;
			bit_q <= BIT_ZERO;
			sda_oe_n_q <= 1'b1;
		end else if (bus_stop) begin
			link_q <= LK_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			unique case (link_q)
				LK_IDLE: begin
				end
				LK_ADDR, LK_WRITE: begin
					if (scl_rise && (bit_q != BIT_LAST)) begin
						sh_q <= {sh_q[6:0], sda_f_q};
						bit_q <= 4'(bit_q + BIT_ONE);
					end else if (byte_done) begin
						if (link_q == LK_WRITE || addr_match) begin
							link_q <= LK_ACK;
							sda_oe_n_q <= 1'b0;
						end else begin
							link_q <= LK_IDLE;
						end
						if (link_q == LK_ADDR) begin
							rw_q <= sh_q[0];
							rd_idx_q <= BYTE_0;
						end
					end
				end
				LK_ACK: begin
					if (scl_fall) begin
						bit_q <= BIT_ZERO;
						if (rw_q) begin
							link_q <= LK_READ;
							sda_oe_n_q <= tx_pick[7];
							tx_q <= {tx_pick[6:0], 1'b0};
							rd_idx_q <= rd_idx_next;
						end else begin
							link_q <= LK_WRITE;
							sda_oe_n_q <= 1'b1;
						end
					end
				end
				LK_READ: begin
					if (scl_rise) begin
						bit_q <= 4'(bit_q + BIT_ONE);
					end else if (scl_fall) begin
						if (bit_q == BIT_LAST) begin
							link_q <= LK_RACK;
							sda_oe_n_q <= 1'b1;
						end else begin
							sda_oe_n_q <= tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				LK_RACK: begin
					if (scl_rise) begin
						nack_q <= sda_f_q;
					end else if (scl_fall) begin
						bit_q <= BIT_ZERO;
						if (nack_q) begin
							link_q <= LK_IDLE;
						end else begin
							link_q <= LK_READ;
							sda_oe_n_q <= tx_pick[7];
							tx_q <= {tx_pick[6:0], 1'b0};
							rd_idx_q <= rd_idx_next;
						end
					end
				end
				default: begin
					link_q <= LK_IDLE;
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end

	// Write-byte capture and transaction tracking
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			in_xfer_q <= 1'b0;
			wr_cnt_q <= WR_NONE;
			cmd_q <= CMD_ARG_ZERO;
			arg1_q <= CMD_ARG_ZERO;
			arg2_q <= CMD_ARG_ZERO;
		end else if (bus_end) begin
			in_xfer_q <= 1'b0;
		end else if (link_q == LK_ADDR && byte_done) begin
			in_xfer_q <= addr_match;
			wr_cnt_q <= WR_NONE;
		end else if (link_q == LK_WRITE && byte_done) begin
			unique case (wr_cnt_q)
				WR_NONE: cmd_q <= sh_q;
				WR_ONE: arg1_q <= sh_q;
				WR_TWO: arg2_q <= sh_q;
				WR_FULL: begin
				end
			endcase
			// Extra bytes beyond three are acknowledged but dropped
			if (wr_cnt_q != WR_FULL) begin
				wr_cnt_q <= 2'(wr_cnt_q + WR_ONE);
			end
		end
	end

	// Measurement sequencer: asleep unless requested
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			meas_q <= MS_SLEEP;
			mcnt_q <= CNT_ZERO;
		end else begin
			unique case (meas_q)
				MS_SLEEP: begin
					if (meas_req) begin
						meas_q <= MS_WAKE;
						mcnt_q <= WAKE_CYC - CNT_ONE;
					end
				end
				MS_WAKE: begin
					if (mcnt_q == CNT_ZERO) begin
						meas_q <= MS_HUM;
						mcnt_q <= res_cycles(hum_res_q) - CNT_ONE;
					end else begin
						mcnt_q <= mcnt_q - CNT_ONE;
					end
				end
				MS_HUM: begin
					if (mcnt_q == CNT_ZERO) begin
						meas_q <= MS_TEMP;
						mcnt_q <= res_cycles(temp_res_q) - CNT_ONE;
					end else begin
						mcnt_q <= mcnt_q - CNT_ONE;
					end
				end
				MS_TEMP: begin
					if (mcnt_q == CNT_ZERO) begin
						meas_q <= MS_SLEEP;
					end else begin
						mcnt_q <= mcnt_q - CNT_ONE;
					end
				end
			endcase
		end
	end

	// Output register; a finishing measurement wins over a fetch
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			result_q.status <= STATUS_STALE;
			result_q.hum <= 14'h0000;
			result_q.temp <= 14'h0000;
		end else if (meas_done) begin
			result_q.status <= STATUS_VALID;
			result_q.hum <= HUM_DATA_I;
			result_q.temp <= TEMP_DATA_I;
		end else if (fetch_done) begin
			result_q.status <= STATUS_STALE;
		end
	end

	// Power-up window, programming mode and non-volatile registers
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			win_q <= PROG_WIN_CYC;
			loading_q <= 1'b0;
			lcnt_q <= CNT_ZERO;
			prog_q <= 1'b0;
		end else begin
			if (win_open) begin
				win_q <= win_q - CNT_ONE;
			end
			if (enter_req) begin
				loading_q <= 1'b1;
				lcnt_q <= PROG_LOAD_CYC - CNT_ONE;
			end else if (loading_q) begin
				if (lcnt_q == CNT_ZERO) begin
					loading_q <= 1'b0;
					prog_q <= 1'b1;
				end else begin
					lcnt_q <= lcnt_q - CNT_ONE;
				end
			end else if (exit_req) begin
				prog_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hum_res_q <= NVM_RES_RESET;
			temp_res_q <= NVM_RES_RESET;
			nvm_busy_q <= 1'b0;
			ncnt_q <= CNT_ZERO;
			rd_ptr_q <= NVM_ID_UPPER;
		end else begin
			if (sel_req) begin
				rd_ptr_q <= cmd_q;
			end
			// Whole word is taken as written; only bits 11:10 steer timing
			if (hum_wr) begin
				hum_res_q <= {arg1_q, arg2_q};
			end
			if (temp_wr) begin
				temp_res_q <= {arg1_q, arg2_q};
			end
			if (hum_wr || temp_wr) begin
				nvm_busy_q <= 1'b1;
				ncnt_q <= NVM_WR_CYC - CNT_ONE;
			end else if (nvm_busy_q) begin
				if (ncnt_q == CNT_ZERO) begin
					nvm_busy_q <= 1'b0;
				end else begin
					ncnt_q <= ncnt_q - CNT_ONE;
				end
			end
		end
	end

	// Open-drain data line: only ever pulls low; rates up to 400 kHz sample safely
	logic sda_o_q;
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0;
		end
	end

	assign SDA_O = sda_o_q;
	assign SDA_OE_N_O = sda_oe_n_q;
	assign MEAS_PHASE_O = meas_q;
	assign RESULT_O = result_q;
	assign PROG_MODE_O = prog_q;
	assign NVM_BUSY_O = nvm_busy_q;
	assign HUM_RES_REG_O = hum_res_q;
	assign TEMP_RES_REG_O = temp_res_q;

endmodule

// ---- hts_readout_monitor.sv ----
`timescale 1ns/1ps
module hts_readout_monitor #(
	parameter logic [31:0] WAKE_CYC = 32'h14,
	parameter logic [31:0] CONV8_CYC = 32'h28,
	parameter logic [31:0] CONV10_CYC = 32'h3C,
	parameter logic [31:0] CONV12_CYC = 32'h50,
	parameter logic [31:0] CONV14_CYC = 32'h64,
	parameter logic [31:0] PROG_WIN_CYC = 32'h4E20,
	parameter logic [31:0] PROG_LOAD_CYC = 32'h1E,
	parameter logic [31:0] NVM_WR_CYC = 32'h32
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_N_O,
	input wire logic [13:0] HUM_DATA_I,
	input wire logic [13:0] TEMP_DATA_I,
	input wire hts_pkg::hts_meas_t MEAS_PHASE_O,
	input wire hts_pkg::hts_result_t RESULT_O,
	input wire logic PROG_MODE_O,
	input wire logic NVM_BUSY_O,
	input wire logic [15:0] HUM_RES_REG_O,
	input wire logic [15:0] TEMP_RES_REG_O
);
	import hts_pkg::*;
	hts_meas_t ph_q;
	logic [31:0] run_q;
	logic [31:0] bz_q;
	logic [31:0] up_q;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	function automatic logic [31:0] conv(input logic [1:0] r);
		return r == RES_8 ? CONV8_CYC : r == RES_10 ? CONV10_CYC :
			r == RES_12 ? CONV12_CYC : CONV14_CYC;
	endfunction
	// Run length of the current phase, busy length and cycles since reset
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ph_q <= MS_SLEEP;
			run_q <= 32'h0;
			bz_q <= 32'h0;
			up_q <= 32'h0;
		end else begin
			ph_q <= MEAS_PHASE_O;
			run_q <= (MEAS_PHASE_O != ph_q) ? 32'h1 : run_q + 32'h1;
			bz_q <= NVM_BUSY_O ? bz_q + 32'h1 : 32'h0;
			up_q <= up_q[31] ? up_q : up_q + 32'h1;
		end
	end
	property p_phase_len;
		(MEAS_PHASE_O != ph_q && ph_q != MS_SLEEP) |-> run_q == (ph_q == MS_WAKE ? WAKE_CYC :
			conv(ph_q == MS_HUM ? HUM_RES_REG_O[11:10] : TEMP_RES_REG_O[11:10]));
	endproperty
	a_phase_len: assert property (p_phase_len) else $error("Phase length wrong");
	property p_phase_order;
		MEAS_PHASE_O != ph_q |-> MEAS_PHASE_O == hts_meas_t'(ph_q + 2'h1);
	endproperty
	a_phase_order: assert property (p_phase_order) else $error("Phase order wrong");
	property p_result;
		(ph_q == MS_TEMP && MEAS_PHASE_O == MS_SLEEP) |->
			RESULT_O == {STATUS_VALID, $past(HUM_DATA_I), $past(TEMP_DATA_I)};
	endproperty
	a_result: assert property (p_result) else $error("Result not loaded");
	property p_data_cause;
		($changed(RESULT_O.hum) || $changed(RESULT_O.temp)) |-> ph_q == MS_TEMP;
	endproperty
	a_data_cause: assert property (p_data_cause) else $error("Result moved idle");
	property p_stale_only;
		($changed(RESULT_O.status) && ph_q != MS_TEMP) |-> RESULT_O.status == STATUS_STALE;
	endproperty
	a_stale_only: assert property (p_stale_only) else $error("Status became valid");
	property p_open_drain;
		!SDA_OE_N_O |-> !SDA_O;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("Data line driven high");
	property p_sda_on_low;
		$changed(SDA_OE_N_O) |-> !SCL_I;
	endproperty
	a_sda_on_low: assert property (p_sda_on_low) else $error("Data moved, clock high");
	property p_busy_len;
		$fell(NVM_BUSY_O) |-> bz_q == NVM_WR_CYC;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("Commit length wrong");
	property p_busy_cause;
		$rose(NVM_BUSY_O) |-> PROG_MODE_O;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("Commit outside programming");
	property p_res_write;
		($changed(HUM_RES_REG_O) || $changed(TEMP_RES_REG_O)) |-> ##[0:1] (NVM_BUSY_O && PROG_MODE_O);
	endproperty
	a_res_write: assert property (p_res_write) else $error("Word changed, no commit");
	property p_window;
		$rose(PROG_MODE_O) |-> up_q <= PROG_WIN_CYC + PROG_LOAD_CYC + 32'h2;
	endproperty
	a_window: assert property (p_window) else $error("Programming entered late");
endmodule
bind hts_readout hts_readout_monitor #(
	.WAKE_CYC(WAKE_CYC), .CONV8_CYC(CONV8_CYC), .CONV10_CYC(CONV10_CYC),
	.CONV12_CYC(CONV12_CYC), .CONV14_CYC(CONV14_CYC), .PROG_WIN_CYC(PROG_WIN_CYC),
	.PROG_LOAD_CYC(PROG_LOAD_CYC), .NVM_WR_CYC(NVM_WR_CYC)
) u_mon (.*);

// ---- hts_master_model.sv ----
`timescale 1ns/1ps
module hts_master_model #(
	parameter int HALF = 20
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// Clock stands high between frames; released data floats to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic start();
		sda_low_o = 1'b1;
		tick(HALF);
		scl_o = 1'b0;
	endtask
	// Data moves a few cycles after SCL falls, so hold time is never marginal
	task automatic one_bit(input logic b, output logic r);
		tick(4);
		sda_low_o = !b;
		tick(HALF - 4);
		scl_o = 1'b1;
		tick(HALF);
		r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			one_bit(d[i], q[i]);
		end
		one_bit(ack_in, ack_out);
	endtask
	task automatic stop();
		tick(4);
		sda_low_o = 1'b1;
		tick(HALF - 4);
		scl_o = 1'b1;
		tick(HALF);
		sda_low_o = 1'b0;
		tick(HALF);
	endtask
endmodule

// ---- hts_readout_bench.sv ----
`timescale 1ns/1ps
module hts_readout_bench;
	import hts_pkg::*;
	localparam logic [6:0] ADDR = ADDR_VARIANT_1;
	logic CLK_I, RST_N_I, SCL_I, SDA_I, SDA_O, SDA_OE_N_O, PROG_MODE_O, NVM_BUSY_O;
	logic [13:0] HUM_DATA_I, TEMP_DATA_I;
	logic [15:0] HUM_RES_REG_O, TEMP_RES_REG_O;
	hts_meas_t MEAS_PHASE_O;
	hts_result_t RESULT_O;
	logic sda_low, ack, addr_ack;
	logic [7:0] rx [0:3];
	int err_total = 0;
	int n_checks = 0;
	logic [7:0] ra [0:5] = '{NVM_ID_UPPER, NVM_ID_LOWER, NVM_HUM_RES_RD, NVM_TEMP_RES_RD,
		8'h10, 8'h20};
	logic [15:0] re [0:5] = '{ID_UPPER_DEFAULT, ID_LOWER_DEFAULT, NVM_RES_RESET, NVM_RES_RESET,
		NVM_NONE, NVM_NONE};
	// Wired-AND with pull-up: either party pulling low wins
	assign SDA_I = !sda_low && (SDA_OE_N_O || SDA_O);
	// Wake-up runs at its full length; only the times the scenarios wait on are shortened
	hts_readout #(
		.CONV10_CYC(32'h3C), .CONV12_CYC(32'h50), .PROG_WIN_CYC(32'h4E20),
		.PROG_LOAD_CYC(32'h1E), .NVM_WR_CYC(32'h32)
	) dut (.*);
	hts_master_model m (
		.clk_i(CLK_I),
		.sda_i(SDA_I),
		.scl_o(SCL_I),
		.sda_low_o(sda_low)
	);
	initial begin
		CLK_I = 1'b0;
		forever #2 CLK_I = ~CLK_I;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input logic [6:0] a, input int n, input logic [23:0] d);
		logic [7:0] q;
		m.start();
		m.xfer({a, 1'b0}, 1'b1, q, addr_ack);
		for (int i = 0; i < n; i++) begin
			m.xfer(d[23 - 8 * i -: 8], 1'b1, q, ack);
		end
		m.stop();
	endtask
	task automatic fetch(input int n);
		logic [7:0] q;
		m.start();
		m.xfer({ADDR, 1'b1}, 1'b1, q, ack);
		chk(ack, 1'b0);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hFF, i == n - 1, rx[i], q[0]);
		end
		m.stop();
	endtask
	task automatic rdreg(input logic [7:0] a, input logic [15:0] w);
		cmd(ADDR, 3, {a, 16'h0});
		fetch(3);
		chk({rx[0], rx[1], rx[2]}, {PROG_STAT_READY, w});
	endtask
	// 0: back to sleep, 1: programming on, 2: commit over, 3: programming off
	task automatic wait_on(input int sel);
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (hit !== 1'b1) begin
			@(negedge CLK_I);
			n++;
			hit = sel == 0 ? MEAS_PHASE_O == MS_SLEEP : sel == 1 ? PROG_MODE_O :
				sel == 2 ? !NVM_BUSY_O : !PROG_MODE_O;
			if (n > 30000) begin
				err_total++;
				tally_and_finish();
			end
		end
	endtask
	initial begin
		RST_N_I = 1'b0;
		HUM_DATA_I = 14'h2ABC;
		TEMP_DATA_I = 14'h1357;
		repeat (3) @(negedge CLK_I);
		RST_N_I = 1'b1;
		chk(RESULT_O, {STATUS_STALE, 28'h0});
		chk({MEAS_PHASE_O, PROG_MODE_O}, {MS_SLEEP, 1'b0});
		chk({HUM_RES_REG_O, TEMP_RES_REG_O}, {NVM_RES_RESET, NVM_RES_RESET});
		fetch(2);
		chk(rx[0][7:6], STATUS_STALE);
		cmd(ADDR_VARIANT_2, 0, 24'h0);
		chk({addr_ack, MEAS_PHASE_O}, {1'b1, MS_SLEEP});
		cmd(ADDR, 3, {CMD_PROG_ENTER, CMD_ARG_ZERO, CMD_ARG_ZERO});
		chk(PROG_MODE_O, 1'b0);
		wait_on(1);
		chk(PROG_MODE_O, 1'b1);
		for (int i = 0; i < 6; i++) begin
			rdreg(ra[i], re[i]);
		end
		cmd(ADDR, 3, {NVM_HUM_RES_WR, 16'h0400});
		chk({HUM_RES_REG_O, NVM_BUSY_O}, {16'h0400, 1'b1});
		wait_on(2);
		cmd(ADDR, 3, {NVM_TEMP_RES_WR, 16'h0800});
		wait_on(2);
		rdreg(NVM_TEMP_RES_RD, 16'h0800);
		rdreg(NVM_HUM_RES_RD, 16'h0400);
		cmd(ADDR, 3, {CMD_PROG_EXIT, CMD_ARG_ZERO, CMD_ARG_ZERO});
		wait_on(3);
		chk(PROG_MODE_O, 1'b0);
		cmd(ADDR, 0, 24'h0);
		chk({addr_ack, MEAS_PHASE_O != MS_SLEEP}, 2'b01);
		wait_on(0);
		chk(RESULT_O, {STATUS_VALID, HUM_DATA_I, TEMP_DATA_I});
		fetch(4);
		chk({rx[0], rx[1], rx[2], rx[3] & 8'hFC},
			{STATUS_VALID, HUM_DATA_I, TEMP_DATA_I, LSB_PAD});
		fetch(3);
		chk({rx[0][7:6], rx[2]}, {STATUS_STALE, TEMP_DATA_I[13:6]});
		repeat (20000) @(negedge CLK_I);
		cmd(ADDR, 3, {CMD_PROG_ENTER, CMD_ARG_ZERO, CMD_ARG_ZERO});
		repeat (40) @(negedge CLK_I);
		chk(PROG_MODE_O, 1'b0);
		tally_and_finish();
	end
endmodule
